// *** hw/mde_exec.sv ***
`timescale 1ns/1ns
`default_nettype none
module mde_exec #(
	parameter int STACK_DEPTH = 8,
	parameter bit PC_WIDE = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire mde_pkg::mde_apb_req_s i_apb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	output logic o_busy
);
	import mde_pkg::*;
	localparam int SPW = $clog2(STACK_DEPTH);
	generate
		if (STACK_DEPTH < 2 || STACK_DEPTH > 128 ||
			(STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
			$error("STACK_DEPTH must be a power of two from 2 to 128");
		end
	endgenerate
	// ==========================================
	// State
	mde_state_e state_reg, state_next;
	logic [31:0] oper_reg, oper_next, zptr_reg, zptr_next;
	logic [21:0] pc_reg, pc_next;
	logic [7:0] flags_reg, flags_next, res_reg, res_next;
	logic [15:0] prod_reg, prod_next;
	logic [31:0] des_reg [4], des_next [4];
	logic [21:0] stk_reg [STACK_DEPTH];
	logic [SPW:0] sp_reg, sp_next;
	logic [2:0] cnt_reg, cnt_next, cyc_reg, cyc_next;
	logic [4:0] op_reg, op_next;
	logic taken_reg, taken_next, err_reg, err_next;
	logic ctl_two_reg, ctl_two_next;
	logic pready_reg, pslverr_reg;
	logic [31:0] prdata_reg, rd_mux;
	logic push, hit, wr, start;
	logic [21:0] push_val;
	// ==========================================
	// Operand views
	logic [7:0] rd, rr, iov, dres;
	logic [2:0] bsel;
	logic [21:0] kext, pc1;
	logic [15:0] zp, prod, uu;
	logic signed [16:0] ss, su;
	logic [8:0] diff;
	logic [63:0] fk, lh, rh;
	logic two;
	assign rd = oper_reg[7:0];
	assign rr = oper_reg[15:8];
	assign bsel = oper_reg[18:16];
	assign kext = {{15{oper_reg[30]}}, oper_reg[30:24]};
	assign zp = zptr_reg[15:0];
	assign iov = zptr_reg[31:24];
	assign pc1 = pc_reg + 22'h000001;
	assign uu = rd * rr;
	assign ss = $signed({rd[7], rd}) * $signed({rr[7], rr});
	assign su = $signed({rd[7], rd}) * $signed({1'b0, rr});
	assign lh = {des_reg[1], des_reg[0]};
	assign rh = {des_reg[3], des_reg[2]};
	assign fk = {8{rd}};
	assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && pready_reg;
	assign start = wr && i_apb.paddr == A_CTRL && state_reg == ST_IDLE;
	// ==========================================
	// Execution and register writes
	always_comb begin
		state_next = state_reg;
		oper_next = oper_reg;
		zptr_next = zptr_reg;
		pc_next = pc_reg;
		flags_next = flags_reg;
		res_next = res_reg;
		prod_next = prod_reg;
		des_next = des_reg;
		sp_next = sp_reg;
		cnt_next = cnt_reg;
		cyc_next = cyc_reg;
		op_next = op_reg;
		taken_next = taken_reg;
		err_next = err_reg;
		ctl_two_next = ctl_two_reg;
		push = 1'b0;
		push_val = pc1;
		prod = 16'h0000;
		diff = 9'h000;
		dres = rd;
		hit = 1'b0;
		two = i_apb.pwdata[CTRL_TWO_W];
		if (state_reg == ST_RUN) begin
			if (cnt_reg == 3'h0) begin
				state_next = ST_IDLE;
			end else begin
				cnt_next = cnt_reg - 3'h1;
			end
		end else if (wr) begin
			if (i_apb.paddr == A_OPER) begin
				oper_next = i_apb.pwdata;
			end else if (i_apb.paddr == A_ZPTR) begin
				zptr_next = i_apb.pwdata;
			end else if (i_apb.paddr == A_PC) begin
				pc_next = i_apb.pwdata[21:0];
			end else if (i_apb.paddr == A_FLAGS) begin
				flags_next = i_apb.pwdata[7:0];
			end else if (i_apb.paddr >= A_DES0 && i_apb.paddr <= A_DES3) begin
				des_next[i_apb.paddr[3:2]] = i_apb.pwdata;
			end
		end
		if (start) begin
			op_next = i_apb.pwdata[4:0];
			ctl_two_next = two;
			taken_next = 1'b0;
			err_next = 1'b0;
			cyc_next = 3'h1;
			pc_next = pc1;
			case (i_apb.pwdata[4:0])
				OP_INC, OP_SUB1, OP_ANDS, OP_ZERO: begin
					case (i_apb.pwdata[4:0])
						OP_INC: dres = rd + 8'h01;
						OP_SUB1: dres = rd - 8'h01;
						OP_ANDS: dres = rd & rd;
						default: dres = 8'h00;
					endcase
					res_next = dres;
					flags_next[FB_Z] = dres == 8'h00;
					flags_next[FB_N] = dres[7];
					flags_next[FB_V] = (i_apb.pwdata[4:0] == OP_INC && rd == 8'h7F) ||
						(i_apb.pwdata[4:0] == OP_SUB1 && rd == 8'h80);
					flags_next[FB_S] = flags_next[FB_N] ^ flags_next[FB_V];
				end
				OP_SER: res_next = 8'hFF;
				OP_PUU, OP_PSS, OP_PSU, OP_FPUU, OP_FPSS, OP_FPSU: begin
					cyc_next = 3'h2;
					case (i_apb.pwdata[4:0])
						OP_PUU, OP_FPUU: prod = uu;
						OP_PSS, OP_FPSS: prod = ss[15:0];
						default: prod = su[15:0];
					endcase
					flags_next[FB_C] = prod[15];
					if (i_apb.pwdata[4:0] >= OP_FPUU) begin
						prod = {prod[14:0], 1'b0};
					end
					prod_next = prod;
					flags_next[FB_Z] = prod == 16'h0000;
				end
				OP_DES: begin
					// One keyed Feistel round; decrypt undoes encrypt with the same K
					if (!flags_reg[FB_H]) begin
						{des_next[1], des_next[0]} = rh;
						{des_next[3], des_next[2]} = lh ^ {rh[60:0], rh[63:61]} ^ fk;
					end else begin
						cyc_next = 3'h2;
						{des_next[3], des_next[2]} = lh;
						{des_next[1], des_next[0]} = rh ^ {lh[60:0], lh[63:61]} ^ fk;
					end
				end
				OP_ZJMP, OP_XZJMP: begin
					cyc_next = 3'h2;
					pc_next = {(i_apb.pwdata[4:0] == OP_XZJMP) ? zptr_reg[21:16] : 6'h00, zp};
				end
				OP_RELCALL, OP_ZCALL, OP_XZCALL: begin
					push = 1'b1;
					cyc_next = PC_WIDE ? 3'h3 : 3'h2;
					if (i_apb.pwdata[4:0] == OP_RELCALL) begin
						pc_next = pc1 + kext;
					end else if (i_apb.pwdata[4:0] == OP_ZCALL) begin
						pc_next = {6'h00, zp};
					end else begin
						cyc_next = 3'h3;
						pc_next = {zptr_reg[21:16], zp};
					end
					if (sp_reg == STACK_DEPTH[SPW:0]) begin
						push = 1'b0;
						err_next = 1'b1;
					end else begin
						sp_next = sp_reg + 1'b1;
					end
				end
				OP_POPPC, OP_IEXIT: begin
					cyc_next = PC_WIDE ? 3'h5 : 3'h4;
					if (sp_reg == '0) begin
						err_next = 1'b1;
					end else begin
						sp_next = sp_reg - 1'b1;
						pc_next = stk_reg[SPW'(sp_reg - 1'b1)];
					end
					if (i_apb.pwdata[4:0] == OP_IEXIT) begin
						flags_next[FB_I] = 1'b1;
					end
				end
				OP_CMP, OP_CMPC, OP_CMPI: begin
					// Compare only: destination byte is left as it was
					diff = {1'b0, rd} - {1'b0, rr} -
						{8'h00, i_apb.pwdata[4:0] == OP_CMPC && flags_reg[FB_C]};
					res_next = rd;
					flags_next[FB_C] = diff[8];
					flags_next[FB_Z] = (diff[7:0] == 8'h00) &&
						(i_apb.pwdata[4:0] != OP_CMPC || flags_reg[FB_Z]);
					flags_next[FB_N] = diff[7];
					flags_next[FB_V] = (rd[7] & ~rr[7] & ~diff[7]) | (~rd[7] & rr[7] & diff[7]);
					flags_next[FB_S] = diff[7] ^ flags_next[FB_V];
					flags_next[FB_H] = (~rd[3] & rr[3]) | (rr[3] & diff[3]) | (diff[3] & ~rd[3]);
				end
				OP_SKEQ, OP_SKRC, OP_SKRS, OP_SKIC, OP_SKIS: begin
					case (i_apb.pwdata[4:0])
						OP_SKEQ: hit = rd == rr;
						OP_SKRC: hit = !rr[bsel];
						OP_SKRS: hit = rr[bsel];
						OP_SKIC: hit = !iov[bsel];
						default: hit = iov[bsel];
					endcase
					taken_next = hit;
					cyc_next = hit ? (two ? 3'h3 : 3'h2) : 3'h1;
					pc_next = hit ? (pc1 + (two ? 22'h000002 : 22'h000001)) : pc1;
					if (i_apb.pwdata[4:0] >= OP_SKIC) begin
						cyc_next = cyc_next + 3'h1;
					end
				end
				default: begin
					if (i_apb.pwdata[4:0] >= OP_BCS) begin
						hit = flags_reg[FB_C] == (i_apb.pwdata[4:0] == OP_BCS);
					end else begin
						hit = flags_reg[bsel] == (i_apb.pwdata[4:0] == OP_BFS);
					end
					taken_next = hit;
					cyc_next = hit ? 3'h2 : 3'h1;
					pc_next = hit ? pc1 + kext : pc1;
				end
			endcase
			cnt_next = cyc_next - 3'h1;
			state_next = ST_RUN;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			state_reg <= ST_IDLE;
			oper_reg <= 32'h00000000;
			zptr_reg <= 32'h00000000;
			pc_reg <= 22'h000000;
			flags_reg <= FLAGS_RST;
			res_reg <= 8'h00;
			prod_reg <= 16'h0000;
			des_reg <= '{default: 32'h00000000};
			sp_reg <= '0;
			cnt_reg <= 3'h0;
			cyc_reg <= 3'h0;
			op_reg <= 5'h00;
			taken_reg <= 1'b0;
			err_reg <= 1'b0;
			ctl_two_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			oper_reg <= oper_next;
			zptr_reg <= zptr_next;
			pc_reg <= pc_next;
			flags_reg <= flags_next;
			res_reg <= res_next;
			prod_reg <= prod_next;
			des_reg <= des_next;
			sp_reg <= sp_next;
			cnt_reg <= cnt_next;
			cyc_reg <= cyc_next;
			op_reg <= op_next;
			taken_reg <= taken_next;
			err_reg <= err_next;
			ctl_two_reg <= ctl_two_next;
		end
	end
	// Return stack: entries need no reset, sp guards them
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			stk_reg[SPW'(sp_reg)] <= push_val;
		end
	end
	// ==========================================
	// APB slave, one wait state
	always_comb begin
		rd_mux = 32'h00000000;
		if (i_apb.paddr == A_CTRL) begin
			rd_mux = {23'h000000, ctl_two_reg, 3'h0, op_reg};
		end else if (i_apb.paddr == A_OPER) begin
			rd_mux = oper_reg;
		end else if (i_apb.paddr == A_ZPTR) begin
			rd_mux = zptr_reg;
		end else if (i_apb.paddr == A_PC) begin
			rd_mux = {10'h000, pc_reg};
		end else if (i_apb.paddr == A_FLAGS) begin
			rd_mux = {24'h000000, flags_reg};
		end else if (i_apb.paddr == A_RES) begin
			rd_mux = {prod_reg, 8'h00, res_reg};
		end else if (i_apb.paddr == A_STAT) begin
			rd_mux = 32'({sp_reg, 6'h00, err_reg, taken_reg, 5'h00, cyc_reg, 7'h00, o_busy});
		end else if (i_apb.paddr >= A_DES0 && i_apb.paddr <= A_DES3) begin
			rd_mux = des_reg[i_apb.paddr[3:2]];
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= i_apb.psel && i_apb.penable && !pready_reg;
			prdata_reg <= rd_mux;
			pslverr_reg <= i_apb.paddr[1:0] != 2'h0 || i_apb.paddr > A_DES3 ||
				(i_apb.paddr > A_STAT && i_apb.paddr < A_DES0);
		end
	end
	assign o_pready = pready_reg;
	assign o_prdata = prdata_reg;
	assign o_pslverr = pslverr_reg;
	assign o_busy = state_reg[1];
	// ==========================================
	// Checks
	logic [2:0] obs_reg;
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst || state_reg == ST_IDLE) begin
			obs_reg <= 3'h0;
		end else begin
			obs_reg <= obs_reg + 3'h1;
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	function automatic logic go(input logic [4:0] op);
		go = start && i_apb.pwdata[4:0] == op;
	endfunction
	busy_length_a: assert property ($fell(o_busy) |-> obs_reg == cyc_reg)
		else $error("busy time differs from cycle count");
	inc_result_a: assert property (go(OP_INC) |=> res_reg == $past(rd) + 8'h01
		##1 !o_busy) else $error("increment wrong or not single cycle");
	uprod_value_a: assert property (go(OP_PUU) |=> prod_reg == $past(uu)
		##2 !o_busy) else $error("unsigned product wrong");
	fprod_shift_a: assert property (go(OP_FPUU) |=> prod_reg == {$past(uu[14:0]), 1'b0} &&
		flags_reg[FB_C] == $past(uu[15])) else $error("fractional product wrong");
	des_cycles_a: assert property (go(OP_DES) |=> cyc_reg == ($past(flags_reg[FB_H]) ?
		3'h2 : 3'h1)) else $error("cipher cycle count wrong");
	zjump_page_a: assert property (go(OP_ZJMP) |=> pc_reg[21:16] == 6'h00 &&
		pc_reg[15:0] == $past(zp)) else $error("indirect jump target wrong");
	xjump_page_a: assert property (go(OP_XZJMP) |=> pc_reg == $past(zptr_reg[21:0])
		) else $error("extended jump target wrong");
	zcall_push_a: assert property (go(OP_ZCALL) && sp_reg == '0 |=> sp_reg == 1 &&
		stk_reg[0] == $past(pc1)) else $error("call did not push return");
	eq_skip_a: assert property (go(OP_SKEQ) && rd == rr && !two |=>
		pc_reg == $past(pc_reg) + 22'h000002 && flags_reg == $past(flags_reg))
		else $error("equal compare did not skip one word");
	io_skip_cycles_a: assert property (go(OP_SKIC) && iov[bsel] |=> cyc_reg == 3'h2)
		else $error("io skip not taken cost wrong");
	branch_not_a: assert property (go(OP_BCC) && flags_reg[FB_C] |=>
		pc_reg == $past(pc1) ##1 !o_busy) else $error("untaken carry branch wrong");
	exit_flag_a: assert property (go(OP_IEXIT) |=> flags_reg[FB_I] ##4
		(o_busy == PC_WIDE)) else $error("interrupt exit wrong");
	cover_prod_c: cover property (go(OP_PSS));
	cover_des_c: cover property (go(OP_DES) && flags_reg[FB_H]);
	cover_br_c: cover property (go(OP_BFS) && flags_reg[bsel]);
	cover_pop_c: cover property (go(OP_POPPC) && sp_reg != '0);
endmodule
`default_nettype wire

// *** hw/mde_pkg.sv ***
// Contract
// - and_self_test_op, add_one_op, sub_one_op update Z,N,V,S in one cycle.
// - Multiplies put 16-bit product in R1:R0, sign per variant; Z,C; two cycles.
// - Fractional multiplies shift product left one bit; Z,C; two cycles.
// - Cipher transforms 128-bit state with K; H=0 encrypts, H=1 decrypts.
// - indirect_z_jump loads PC 15:0 from Z, clears 21:16; two cycles.
// - extended_indirect_z_jump takes PC 21:16 from extended_jump_page_reg; two cycles.
// - indirect_z_call pushes return, PC from Z; 2/3 cycles, relative_call_op same.
// - extended_indirect_z_call pushes return, page from extended register; three cycles.
// - compare_skip_equal_op skips next on Rd equal Rr; 1/2/3 cycles; no flags.
// - Register bit skips on clear or set; 1/2/3 cycles.
// - I/O bit skips on clear or set; 2/3/4 cycles.
// - Flag branches go to PC+k+1 on flag set or clear; 1/2 cycles.
// - Carry branches are flag branches on C; 1/2 cycles.
package mde_pkg;
	// ==========================================
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPER = 8'h04;
	localparam logic [7:0] A_ZPTR = 8'h08;
	localparam logic [7:0] A_PC = 8'h0C;
	localparam logic [7:0] A_FLAGS = 8'h10;
	localparam logic [7:0] A_RES = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_DES0 = 8'h20;
	localparam logic [7:0] A_DES3 = 8'h2C;
	// ==========================================
	// Status flag bit positions
	localparam int FB_C = 0;
	localparam int FB_Z = 1;
	localparam int FB_N = 2;
	localparam int FB_V = 3;
	localparam int FB_S = 4;
	localparam int FB_H = 5;
	localparam int FB_I = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam int CTRL_TWO_W = 8;
	// ==========================================
	// Operation codes
	localparam logic [4:0] OP_INC = 5'h00;
	localparam logic [4:0] OP_SUB1 = 5'h01;
	localparam logic [4:0] OP_ANDS = 5'h02;
	localparam logic [4:0] OP_ZERO = 5'h03;
	localparam logic [4:0] OP_SER = 5'h04;
	localparam logic [4:0] OP_PUU = 5'h05;
	localparam logic [4:0] OP_PSS = 5'h06;
	localparam logic [4:0] OP_PSU = 5'h07;
	localparam logic [4:0] OP_FPUU = 5'h08;
	localparam logic [4:0] OP_FPSS = 5'h09;
	localparam logic [4:0] OP_FPSU = 5'h0A;
	localparam logic [4:0] OP_DES = 5'h0B;
	localparam logic [4:0] OP_ZJMP = 5'h0C;
	localparam logic [4:0] OP_XZJMP = 5'h0D;
	localparam logic [4:0] OP_RELCALL = 5'h0E;
	localparam logic [4:0] OP_ZCALL = 5'h0F;
	localparam logic [4:0] OP_XZCALL = 5'h10;
	localparam logic [4:0] OP_POPPC = 5'h11;
	localparam logic [4:0] OP_IEXIT = 5'h12;
	localparam logic [4:0] OP_SKEQ = 5'h13;
	localparam logic [4:0] OP_CMP = 5'h14;
	localparam logic [4:0] OP_CMPC = 5'h15;
	localparam logic [4:0] OP_CMPI = 5'h16;
	localparam logic [4:0] OP_SKRC = 5'h17;
	localparam logic [4:0] OP_SKRS = 5'h18;
	localparam logic [4:0] OP_SKIC = 5'h19;
	localparam logic [4:0] OP_SKIS = 5'h1A;
	localparam logic [4:0] OP_BFS = 5'h1B;
	localparam logic [4:0] OP_BFC = 5'h1C;
	localparam logic [4:0] OP_BCS = 5'h1D;
	localparam logic [4:0] OP_BCC = 5'h1E;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} mde_state_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} mde_apb_req_s;
endpackage

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import mde_pkg::*;
	logic clk;
	logic nrst;
	mde_apb_req_s req;
	logic pready;
	logic pslverr;
	logic busy;
	logic [31:0] prdata;
	logic [31:0] q;
	logic [31:0] st;
	logic e;
	logic [63:0] l;
	logic [63:0] r;
	logic [63:0] nr;
	logic [127:0] sv0;
	logic [127:0] sv1;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;

	mde_exec #(.STACK_DEPTH(8), .PC_WIDE(1'b1)) dut (.i_ref_clk(clk), .i_nrst(nrst),
		.i_apb(req), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.o_busy(busy));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	task give_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ==========================================
	// Bus access
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		req <= '0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		xfer(1'b0, a, 32'h0);
		chk(q & m, v);
	endtask

	task idle;
		do xfer(1'b0, A_STAT, 32'h0); while (q[0] !== 1'b0);
		st = q;
	endtask

	task run(input logic [4:0] op, input logic two, input logic [31:0] oper);
		wr(A_OPER, oper);
		wr(A_CTRL, {23'h0, two, 3'h0, op});
		idle();
	endtask

	// ==========================================
	// Operation checks
	task alu(input logic [4:0] op, input logic [31:0] oper, input logic [7:0] s0,
		input logic [31:0] rm, rv, input logic [7:0] sm, sv, input logic [2:0] cyc);
		wr(A_FLAGS, {24'h0, s0});
		run(op, 1'b0, oper);
		chk({29'h0, st[10:8]}, {29'h0, cyc});
		rdm(A_RES, rm, rv);
		rdm(A_FLAGS, {24'h0, sm}, {24'h0, sv});
	endtask

	task ctl(input logic [4:0] op, input logic two, input logic [31:0] oper, pc0, pc1,
		input logic [2:0] cyc, input logic tk);
		wr(A_PC, pc0);
		run(op, two, oper);
		chk({29'h0, st[10:8]}, {29'h0, cyc});
		if (op >= OP_SKEQ)
			chk({31'h0, st[16]}, {31'h0, tk});
		rdm(A_PC, 32'hFFFFFFFF, pc1);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		req = '0;
		nrst = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rdm(A_FLAGS, 32'hFF, {24'h0, FLAGS_RST});
		xfer(1'b0, 8'h1C, 32'h0);
		chk({31'h0, e}, 32'h1);
		alu(OP_INC, 32'h7F, 8'h00, 32'hFF, 32'h80, 8'hFF, 8'h0C, 3'h1);
		alu(OP_SUB1, 32'h01, 8'h21, 32'hFF, 32'h00, 8'hFF, 8'h23, 3'h1);
		alu(OP_ANDS, 32'h80, 8'h00, 32'hFF, 32'h80, 8'hFF, 8'h14, 3'h1);
		alu(OP_ZERO, 32'h5A, 8'h00, 32'hFF, 32'h00, 8'hFF, 8'h02, 3'h1);
		alu(OP_SER, 32'h12, 8'h15, 32'hFF, 32'hFF, 8'hFF, 8'h15, 3'h1);
		alu(OP_PUU, 32'hFFFF, 8'h00, 32'hFFFF0000, 32'hFE010000, 8'h03, 8'h01, 3'h2);
		alu(OP_PUU, 32'h3700, 8'h00, 32'hFFFF0000, 32'h0, 8'h03, 8'h02, 3'h2);
		alu(OP_PSS, 32'hFFFF, 8'h00, 32'hFFFF0000, 32'h00010000, 8'h03, 8'h00, 3'h2);
		alu(OP_PSU, 32'hFFFF, 8'h00, 32'hFFFF0000, 32'hFF010000, 8'h03, 8'h01, 3'h2);
		alu(OP_FPUU, 32'h8080, 8'h00, 32'hFFFF0000, 32'h80000000, 8'h02, 8'h00, 3'h2);
		alu(OP_FPSS, 32'h8080, 8'h00, 32'hFFFF0000, 32'h80000000, 8'h02, 8'h00, 3'h2);
		alu(OP_FPSU, 32'h4080, 8'h00, 32'hFFFF0000, 32'hC0000000, 8'h03, 8'h01, 3'h2);
		alu(OP_CMP, 32'h2010, 8'h00, 32'hFF, 32'h10, 8'hFF, 8'h15, 3'h1);
		alu(OP_CMPI, 32'h2010, 8'h00, 32'hFF, 32'h10, 8'hFF, 8'h15, 3'h1);
		alu(OP_CMPC, 32'h1F20, 8'h03, 32'hFF, 32'h20, 8'hFF, 8'h22, 3'h1);
		// Cipher round: right half moves left, left half is mixed with rotated right half and key byte
		sv0 = 128'h4B5A69780F1E2D3C89ABCDEF01234567;
		l = sv0[63:0];
		r = sv0[127:64];
		nr = l ^ {r[60:0], r[63:61]} ^ {8{8'h5A}};
		sv1 = {nr, r};
		for (int i = 0; i < 4; i++)
			wr(A_DES0 + 8'(4 * i), sv0[32 * i +: 32]);
		alu(OP_DES, 32'h5A, 8'h00, 32'h0, 32'h0, 8'h00, 8'h00, 3'h1);
		for (int i = 0; i < 4; i++)
			rdm(A_DES0 + 8'(4 * i), 32'hFFFFFFFF, sv1[32 * i +: 32]);
		alu(OP_DES, 32'h5A, 8'h20, 32'h0, 32'h0, 8'h00, 8'h00, 3'h2);
		for (int i = 0; i < 4; i++)
			rdm(A_DES0 + 8'(4 * i), 32'hFFFFFFFF, sv0[32 * i +: 32]);
		wr(A_ZPTR, 32'hA53F1234);
		ctl(OP_ZJMP, 1'b0, 32'h0, 32'h100, 32'h1234, 3'h2, 1'b0);
		ctl(OP_XZJMP, 1'b0, 32'h0, 32'h100, 32'h3F1234, 3'h2, 1'b0);
		ctl(OP_RELCALL, 1'b0, 32'h05000000, 32'h100, 32'h106, 3'h3, 1'b0);
		ctl(OP_ZCALL, 1'b0, 32'h0, 32'h106, 32'h1234, 3'h3, 1'b0);
		ctl(OP_XZCALL, 1'b0, 32'h0, 32'h1234, 32'h3F1234, 3'h3, 1'b0);
		ctl(OP_POPPC, 1'b0, 32'h0, 32'h3F1234, 32'h1235, 3'h5, 1'b0);
		wr(A_FLAGS, 32'h0);
		ctl(OP_IEXIT, 1'b0, 32'h0, 32'h1235, 32'h107, 3'h5, 1'b0);
		rdm(A_FLAGS, 32'h80, 32'h80);
		// A write landing while busy must be dropped
		wr(A_CTRL, {27'h0, OP_POPPC});
		wr(A_PC, 32'h55);
		idle();
		chk({29'h0, st[10:8]}, 32'h5);
		rdm(A_PC, 32'hFFFFFFFF, 32'h101);
		wr(A_FLAGS, 32'h15);
		ctl(OP_SKEQ, 1'b1, 32'h3333, 32'h200, 32'h203, 3'h3, 1'b1);
		ctl(OP_SKEQ, 1'b0, 32'h3333, 32'h200, 32'h202, 3'h2, 1'b1);
		ctl(OP_SKEQ, 1'b0, 32'h3433, 32'h200, 32'h201, 3'h1, 1'b0);
		ctl(OP_SKRC, 1'b0, 32'h20400, 32'h200, 32'h201, 3'h1, 1'b0);
		ctl(OP_SKRS, 1'b0, 32'h20400, 32'h200, 32'h202, 3'h2, 1'b1);
		ctl(OP_SKRS, 1'b1, 32'h20400, 32'h200, 32'h203, 3'h3, 1'b1);
		ctl(OP_SKIC, 1'b1, 32'h10000, 32'h200, 32'h203, 3'h4, 1'b1);
		ctl(OP_SKIC, 1'b0, 32'h10000, 32'h200, 32'h202, 3'h3, 1'b1);
		ctl(OP_SKIS, 1'b0, 32'h10000, 32'h200, 32'h201, 3'h2, 1'b0);
		ctl(OP_BFS, 1'b0, 32'h7D000000, 32'h200, 32'h1FE, 3'h2, 1'b1);
		ctl(OP_BFC, 1'b0, 32'h7D000000, 32'h200, 32'h201, 3'h1, 1'b0);
		ctl(OP_BFC, 1'b0, 32'h7D010000, 32'h200, 32'h1FE, 3'h2, 1'b1);
		ctl(OP_BFS, 1'b0, 32'h7D010000, 32'h200, 32'h201, 3'h1, 1'b0);
		ctl(OP_BCS, 1'b0, 32'h3F000000, 32'h200, 32'h240, 3'h2, 1'b1);
		ctl(OP_BCC, 1'b0, 32'h3F000000, 32'h200, 32'h201, 3'h1, 1'b0);
		rdm(A_FLAGS, 32'hFF, 32'h15);
		give_verdict();
	end
endmodule
`default_nettype wire
